// ==== rtcio_pkg.sv ====
// constants shared by the interrupt, square-wave and prescaler logic
package rtcio_pkg;

  // system clock and crystal rates
  localparam int CLK_HZ  = 125_000_000;
  localparam int XTAL_HZ = 32768;

  // prescaler layout: F0 is bit 0, the top stage is bit 14
  localparam int PRESC_W   = 15;
  localparam int STOP_LO   = 2;  // lowest stage held by stop
  localparam int EXT_LO    = 9;  // stage fed by the pin in test mode
  localparam int HZ64_BIT  = 8;  // stage that runs at 64 Hz
  localparam int TOP_BIT   = 14; // stage whose rise advances the time
  localparam int SW_16K_BIT = 0;
  localparam int SW_8K_BIT  = 1;
  localparam int SW_4K_BIT  = 2;
  localparam int SW_2K_BIT  = 3;
  localparam int SW_1K_BIT  = 4;

  // square-wave rate selections
  localparam logic [2:0] SW_SEL_32K   = 3'h0;
  localparam logic [2:0] SW_SEL_16K   = 3'h1;
  localparam logic [2:0] SW_SEL_8K    = 3'h2;
  localparam logic [2:0] SW_SEL_4K    = 3'h3;
  localparam logic [2:0] SW_SEL_2K    = 3'h4;
  localparam logic [2:0] SW_SEL_1K    = 3'h5;
  localparam logic [2:0] SW_SEL_1HZ   = 3'h6;
  localparam logic [2:0] SW_SEL_OFF   = 3'h7;
  localparam logic [2:0] SW_SEL_RESET = 3'h0;

  // countdown source clock selections
  localparam logic [1:0] CD_SRC_4096 = 2'h0;
  localparam logic [1:0] CD_SRC_64   = 2'h1;
  localparam logic [1:0] CD_SRC_1    = 2'h2;
  localparam logic [1:0] CD_SRC_1_60 = 2'h3;

  // pulse widths as the denominator of one second
  localparam int TICK_PULSE_HZ = 64;
  localparam int CD_4K_ONE_HZ  = 8192;
  localparam int CD_4K_HZ      = 4096;
  localparam int CD_64_ONE_HZ  = 128;
  localparam int CD_SLOW_HZ    = 64;

  // pulse widths in crystal periods
  localparam int PW_W = 10;
  localparam logic [PW_W-1:0] CD_4K_ONE_LEN = PW_W'(XTAL_HZ / CD_4K_ONE_HZ);
  localparam logic [PW_W-1:0] CD_4K_LEN     = PW_W'(XTAL_HZ / CD_4K_HZ);
  localparam logic [PW_W-1:0] CD_64_ONE_LEN = PW_W'(XTAL_HZ / CD_64_ONE_HZ);
  localparam logic [PW_W-1:0] CD_SLOW_LEN   = PW_W'(XTAL_HZ / CD_SLOW_HZ);

  // synchroniser channel count and channel numbers
  localparam int SYNC_N    = 2;
  localparam int SYNC_XTAL = 0;
  localparam int SYNC_PIN  = 1;

endpackage : rtcio_pkg

// ==== rtcio_prescaler.sv ====
// fifteen-stage prescaler with stop hold and external test feed
`timescale 1ns/1ps
module rtcio_prescaler
  import rtcio_pkg::*;
(
  input  wire logic               clk_sys_in,
  input  wire logic               arst_n_in,
  input  wire logic               xtal_tick_in,
  input  wire logic               ext_edge_in,
  input  wire logic               test_in,
  input  wire logic               stop_in,
  output logic [rtcio_pkg::PRESC_W-1:0] stage_out,
  output logic                    sec_tick_out,
  output logic                    hz64_tick_out
);
  import rtcio_pkg::*;

  logic [PRESC_W-1:0] next_stage;

  // advance from the crystal, or the upper stages from the pin in test
  always_comb begin
    next_stage = stage_out;
    if (test_in) begin
      if (ext_edge_in) begin
        next_stage[TOP_BIT:EXT_LO] = (TOP_BIT-EXT_LO+1)'(
          stage_out[TOP_BIT:EXT_LO] + 1'b1); // [RULE15]
      end
    end else if (xtal_tick_in) begin
      next_stage = PRESC_W'(stage_out + 1'b1); // [RULE22] [RULE24]
    end
    if (stop_in) begin
      next_stage[TOP_BIT:STOP_LO] = '0; // [RULE16] [RULE18]
    end
  end

  // prescaler stages
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stage_out <= '0;
    end else begin
      stage_out <= next_stage;
    end
  end

  // one-second tick on the rise of the top stage
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sec_tick_out <= 1'b0;
    end else begin
      sec_tick_out <= next_stage[TOP_BIT] & ~stage_out[TOP_BIT]; // [RULE22] [RULE17]
    end
  end

  // internal 64 hz timing tick, from the pin while in test mode;
  // the fall of the stage lines up with the second step, so a tick pulse lasts a full period
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hz64_tick_out <= 1'b0;
    end else if (test_in) begin
      hz64_tick_out <= ext_edge_in & ~stop_in;
    end else begin
      hz64_tick_out <= ~next_stage[HZ64_BIT] & stage_out[HZ64_BIT]; // [RULE3]
    end
  end

endmodule : rtcio_prescaler

// ==== rtcio_irq_square_wave_pin.sv ====
// interrupt merge, square-wave output and stop/test timebase control
//
// Overview of operation
// [RULE1] irq pin is active low, a wired or of tick, countdown and alarm.
// [RULE2] pulse mode select picks pulse or flag level for timer interrupts.
// [RULE3] tick interrupt pulse lasts one period of the 64 hz clock.
// [RULE4] clearing the tick flag ends a running tick pulse early.
// [RULE5] in level mode both tick enables low remove the tick request.
// [RULE6] countdown requests reach the pin only while its enable is set.
// [RULE7] countdown pulse width follows source clock and a reload of one.
// [RULE8] clearing the countdown flag ends a running countdown pulse.
// [RULE9] in level mode a low countdown enable removes that request.
// [RULE10] alarm drives the pin as a level of its flag when enabled.
// [RULE11] a three-bit select picks the square-wave rate or constant low.
// [RULE12] square-wave pin is open drain, on at crystal rate, floats off.
// [RULE13] all rates below the crystal rate have equal high and low time.
// [RULE14] stop forces low for 4096 hz and below, upper rates run on.
// [RULE15] test mode makes the pin an input; 64 edges make one second.
// [RULE16] stop holds stages two to fourteen reset, freezing the time.
// [RULE17] after stop in test mode, 32 edges then every 64 edges.
// [RULE18] the two lowest stages ignore stop, first step near half a second.
// [RULE19] host sets then clears stop before loading time in test mode.
// [RULE20] flag writes are anded: a one keeps a flag, a zero clears it.
// [RULE21] tick flag sets on second steps, or minutes with only minute enable.
// [RULE22] time advances on each rise of the top prescaler stage.
// [RULE23] irq pin is released only when no enabled source requests.
// [RULE24] leaving test mode restores the output and the crystal timebase.
`timescale 1ns/1ps
module rtcio_irq_square_wave_pin
  import rtcio_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  // crystal and pin
  input  wire logic        xtal_in,
  input  wire logic        square_wave_pin_in,
  // control bits
  input  wire logic        pulse_mode_sel_in,
  input  wire logic        slow_tick_irq_en_in,
  input  wire logic        fast_tick_irq_en_in,
  input  wire logic        countdown_irq_en_in,
  input  wire logic        alarm_irq_en_in,
  input  wire logic [2:0]  square_wave_rate_sel_in,
  input  wire logic        square_wave_en_in,
  input  wire logic        external_clock_test_in,
  input  wire logic        stop_in,
  // events from the counters
  input  wire logic        minute_inc_in,
  input  wire logic        countdown_event_in,
  input  wire logic [1:0]  countdown_src_sel_in,
  input  wire logic        countdown_reload_one_in,
  input  wire logic        alarm_event_in,
  // flag write
  input  wire logic        flag_wr_in,
  input  wire logic        flag_wr_tick_in,
  input  wire logic        flag_wr_countdown_in,
  input  wire logic        flag_wr_alarm_in,
  // outputs
  output logic             irq_n_out,
  output logic             square_wave_pin_out,
  output logic             square_wave_pin_oe_out,
  output logic             sec_tick_out,
  output logic             hz64_tick_out,
  output logic             tick_flag_out,
  output logic             countdown_flag_out,
  output logic             alarm_flag_out,
  output logic [rtcio_pkg::PRESC_W-1:0] prescaler_out
);
  import rtcio_pkg::*;

  logic [SYNC_N-1:0] sync_ff1;
  logic [SYNC_N-1:0] sync_ff2;
  logic [SYNC_N-1:0] sync_ff3;
  logic [SYNC_N-1:0] sync_raw;
  logic              xtal_tick;
  logic              ext_edge;
  logic              tick_evt;
  logic              tick_clr;
  logic              cd_clr;
  logic              al_clr;
  logic              tick_pulse;
  logic [PW_W-1:0]   cd_cnt;
  logic [PW_W-1:0]   cd_len;
  logic              tick_req;
  logic              cd_req;
  logic              al_req;
  logic              next_sw_level;

  assign sync_raw[SYNC_XTAL] = xtal_in;
  assign sync_raw[SYNC_PIN]  = square_wave_pin_in;

  // two-stage synchronisers plus an edge register per input
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sync_ff1[gi] <= 1'b0;
          sync_ff2[gi] <= 1'b0;
          sync_ff3[gi] <= 1'b0;
        end else begin
          sync_ff1[gi] <= sync_raw[gi];
          sync_ff2[gi] <= sync_ff1[gi];
          sync_ff3[gi] <= sync_ff2[gi];
        end
      end
    end
  endgenerate

  // rising edges of the crystal and of the test input
  assign xtal_tick = sync_ff2[SYNC_XTAL] & ~sync_ff3[SYNC_XTAL];
  assign ext_edge  = sync_ff2[SYNC_PIN] & ~sync_ff3[SYNC_PIN]
                   & external_clock_test_in; // [RULE15]

  // prescaler; the host is expected to pulse stop after entering test
  rtcio_prescaler u_presc (
    .clk_sys_in    (clk_sys_in),
    .arst_n_in     (arst_n_in),
    .xtal_tick_in  (xtal_tick),
    .ext_edge_in   (ext_edge),
    .test_in       (external_clock_test_in), // [RULE19] [RULE24]
    .stop_in       (stop_in),
    .stage_out     (prescaler_out),
    .sec_tick_out  (sec_tick_out),
    .hz64_tick_out (hz64_tick_out)
  );

  // tick event: seconds when the fast enable is on, else minutes
  assign tick_evt = (fast_tick_irq_en_in & sec_tick_out)
                  | (slow_tick_irq_en_in & ~fast_tick_irq_en_in
                     & minute_inc_in); // [RULE21]

  // anded flag writes: a zero in a bit clears that flag
  assign tick_clr = flag_wr_in & ~flag_wr_tick_in; // [RULE20]
  assign cd_clr   = flag_wr_in & ~flag_wr_countdown_in; // [RULE20]
  assign al_clr   = flag_wr_in & ~flag_wr_alarm_in; // [RULE20]

  // tick flag, a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_flag_out <= 1'b0;
    end else if (tick_evt) begin
      tick_flag_out <= 1'b1; // [RULE21]
    end else if (tick_clr) begin
      tick_flag_out <= 1'b0; // [RULE20]
    end
  end

  // countdown flag
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      countdown_flag_out <= 1'b0;
    end else if (countdown_event_in) begin
      countdown_flag_out <= 1'b1;
    end else if (cd_clr) begin
      countdown_flag_out <= 1'b0; // [RULE20]
    end
  end

  // alarm flag
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      alarm_flag_out <= 1'b0;
    end else if (alarm_event_in) begin
      alarm_flag_out <= 1'b1;
    end else if (al_clr) begin
      alarm_flag_out <= 1'b0; // [RULE20]
    end
  end

  // tick pulse: starts on the event, ends at the next 64 hz tick
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_pulse <= 1'b0;
    end else if (!pulse_mode_sel_in) begin
      tick_pulse <= 1'b0;
    end else if (tick_evt) begin
      tick_pulse <= 1'b1; // [RULE3]
    end else if (tick_clr) begin
      tick_pulse <= 1'b0; // [RULE4]
    end else if (hz64_tick_out) begin
      tick_pulse <= 1'b0; // [RULE3]
    end
  end

  // countdown pulse width from source clock and reload value
  always_comb begin
    cd_len = CD_SLOW_LEN;
    case (countdown_src_sel_in)
      CD_SRC_4096: begin
        cd_len = countdown_reload_one_in ? CD_4K_ONE_LEN : CD_4K_LEN; // [RULE7]
      end
      CD_SRC_64: begin
        cd_len = countdown_reload_one_in ? CD_64_ONE_LEN : CD_SLOW_LEN; // [RULE7]
      end
      default: begin
        cd_len = CD_SLOW_LEN; // [RULE7]
      end
    endcase
  end

  // countdown pulse counter in crystal periods
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cd_cnt <= '0;
    end else if (!pulse_mode_sel_in) begin
      cd_cnt <= '0;
    end else if (countdown_event_in) begin
      cd_cnt <= cd_len; // [RULE7]
    end else if (cd_clr) begin
      cd_cnt <= '0; // [RULE8]
    end else if (xtal_tick && cd_cnt != '0) begin
      cd_cnt <= PW_W'(cd_cnt - 1'b1);
    end
  end

  // requests of the three groups
  assign tick_req = pulse_mode_sel_in ? tick_pulse // [RULE2]
                  : tick_flag_out & (slow_tick_irq_en_in
                                     | fast_tick_irq_en_in); // [RULE5]
  assign cd_req   = countdown_irq_en_in // [RULE6] [RULE9]
                  & (pulse_mode_sel_in ? (cd_cnt != '0)
                                       : countdown_flag_out); // [RULE2]
  assign al_req   = alarm_irq_en_in & alarm_flag_out; // [RULE10]

  // active-low interrupt pin, wired or of the groups
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_n_out <= 1'b1;
    end else begin
      irq_n_out <= ~(tick_req | cd_req | al_req); // [RULE1] [RULE23]
    end
  end

  // square-wave level; lower rates come from toggling stages
  always_comb begin
    next_sw_level = 1'b0;
    case (square_wave_rate_sel_in)
      SW_SEL_32K: begin
        next_sw_level = sync_ff2[SYNC_XTAL]; // [RULE11] [RULE13]
      end
      SW_SEL_16K: begin
        next_sw_level = prescaler_out[SW_16K_BIT]; // [RULE14]
      end
      SW_SEL_8K: begin
        next_sw_level = prescaler_out[SW_8K_BIT]; // [RULE14]
      end
      SW_SEL_4K: begin
        next_sw_level = prescaler_out[SW_4K_BIT]; // [RULE14]
      end
      SW_SEL_2K: begin
        next_sw_level = prescaler_out[SW_2K_BIT]; // [RULE13]
      end
      SW_SEL_1K: begin
        next_sw_level = prescaler_out[SW_1K_BIT]; // [RULE11]
      end
      SW_SEL_1HZ: begin
        next_sw_level = prescaler_out[TOP_BIT]; // [RULE11]
      end
      default: begin
        next_sw_level = 1'b0; // [RULE11]
      end
    endcase
  end

  // open-drain pin: only ever pulls low, floats when off or in test
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      square_wave_pin_out <= 1'b0;
    end else begin
      square_wave_pin_out <= 1'b0; // [RULE12]
    end
  end

  // pin driver enable
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      square_wave_pin_oe_out <= 1'b0;
    end else begin
      square_wave_pin_oe_out <= square_wave_en_in // [RULE12]
                              & ~external_clock_test_in // [RULE15] [RULE24]
                              & ~next_sw_level;
    end
  end

endmodule : rtcio_irq_square_wave_pin

// ==== rtcio_far_model.sv ====
// far-end model: crystal source and open-drain pin wire with pull-up
`timescale 1ns/1ps
module rtcio_far_model (
  input  wire logic clk_sys_in,
  input  wire logic oe_in,
  input  wire logic test_drv_in,
  input  wire logic test_lvl_in,
  output logic      xtal_out,
  output logic      pin_out
);
  int div = 0;
  // crystal stand-in, one tick every ten system cycles
  initial xtal_out = 1'h0;
  always @(posedge clk_sys_in) begin
    div = (div == 4) ? 0 : div + 1;
    if (div == 0) xtal_out <= ~xtal_out;
  end
  // wire level: device pulls low, else test driver, else pull-up
  assign pin_out = oe_in ? 1'h0 : (test_drv_in ? test_lvl_in : 1'h1);
endmodule : rtcio_far_model

// ==== rtcio_irq_chk_props.sv ====
// checker for interrupt merge, square-wave output and prescaler stop
`timescale 1ns/1ps
module rtcio_irq_chk
  import rtcio_pkg::*;
(
  input wire logic       clk_sys_in,
  input wire logic       arst_n_in,
  input wire logic       alarm_irq_en_in,
  input wire logic       fast_tick_irq_en_in,
  input wire logic       flag_wr_in,
  input wire logic       flag_wr_tick_in,
  input wire logic       square_wave_en_in,
  input wire logic       external_clock_test_in,
  input wire logic       stop_in,
  input wire logic [2:0] square_wave_rate_sel_in,
  input wire logic       irq_n_out,
  input wire logic       square_wave_pin_oe_out,
  input wire logic       sec_tick_out,
  input wire logic       tick_flag_out,
  input wire logic       countdown_flag_out,
  input wire logic       alarm_flag_out,
  input wire logic [rtcio_pkg::PRESC_W-1:0] prescaler_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // interrupt pin and flags
  alarm_level_a: assert property (alarm_irq_en_in && alarm_flag_out |=> !irq_n_out)
    else $error("alarm not on irq");
  irq_free_a: assert property (!alarm_flag_out && !tick_flag_out && !countdown_flag_out |=> irq_n_out)
    else $error("irq low without flag");
  flag_keep_a: assert property (flag_wr_in && flag_wr_tick_in && tick_flag_out |=> tick_flag_out)
    else $error("tick flag lost");
  tick_set_a: assert property (fast_tick_irq_en_in && sec_tick_out |=> tick_flag_out)
    else $error("tick flag not set");
  // square-wave pin
  sq_float_a: assert property (!square_wave_en_in || external_clock_test_in |=> !square_wave_pin_oe_out)
    else $error("pin driven while off");
  sq_off_a: assert property ((square_wave_en_in && !external_clock_test_in && square_wave_rate_sel_in == SW_SEL_OFF)[*4] |-> square_wave_pin_oe_out)
    else $error("pin not held low");
  stop_low_a: assert property ((stop_in && square_wave_en_in && !external_clock_test_in && square_wave_rate_sel_in inside {[SW_SEL_4K:SW_SEL_1HZ]})[*5] |-> square_wave_pin_oe_out)
    else $error("pin not low in stop");
  // prescaler
  stop_hold_a: assert property (stop_in |=> prescaler_out[TOP_BIT:STOP_LO] == '0)
    else $error("stages run in stop");
  sec_rise_a: assert property ($rose(prescaler_out[TOP_BIT]) |-> sec_tick_out)
    else $error("no second tick");
  cov_alarm_c: cover property (alarm_flag_out && !irq_n_out);
  cov_sec_c: cover property (sec_tick_out ##1 tick_flag_out);
  cov_stop_c: cover property (stop_in && square_wave_pin_oe_out);
endmodule : rtcio_irq_chk

bind rtcio_irq_square_wave_pin rtcio_irq_chk u_chk (.*);

// ==== tb_top.sv ====
// testbench: interrupt merge, square wave, stop and external clock test
`timescale 1ns/1ps
module tb_top;
  import rtcio_pkg::*;
  logic clk_sys_in = 1'h0, arst_n_in = 1'h0, pulse_mode_sel_in = 1'h1, square_wave_en_in = 1'h1;
  logic slow_tick_irq_en_in = 1'h0, fast_tick_irq_en_in = 1'h0, countdown_irq_en_in = 1'h0;
  logic alarm_irq_en_in = 1'h0, external_clock_test_in = 1'h0, stop_in = 1'h0;
  logic minute_inc_in = 1'h0, countdown_event_in = 1'h0, countdown_reload_one_in = 1'h0;
  logic alarm_event_in = 1'h0, flag_wr_in = 1'h0, flag_wr_tick_in = 1'h0;
  logic flag_wr_countdown_in = 1'h0, flag_wr_alarm_in = 1'h0, tdrv = 1'h0, tlvl = 1'h0;
  logic [2:0] square_wave_rate_sel_in = SW_SEL_RESET;
  logic [1:0] countdown_src_sel_in = CD_SRC_4096;
  logic xtal_in, square_wave_pin_in, irq_n_out, square_wave_pin_out, square_wave_pin_oe_out;
  logic sec_tick_out, hz64_tick_out, tick_flag_out, countdown_flag_out, alarm_flag_out;
  logic [PRESC_W-1:0] prescaler_out;
  int mismatches = 0, n_tests = 0, secs = 0;

  rtcio_irq_square_wave_pin i_dut (.*);
  rtcio_far_model i_far (
    .clk_sys_in  (clk_sys_in),
    .oe_in       (square_wave_pin_oe_out),
    .test_drv_in (tdrv),
    .test_lvl_in (tlvl),
    .xtal_out    (xtal_in),
    .pin_out     (square_wave_pin_in)
  );
  // clock and tally of second ticks
  initial forever #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (sec_tick_out === 1'h1) secs++;

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc
  task automatic chk(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic rng(input string what, input int lo, hi, got);
    n_tests++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : rng
  // flag write: a one keeps a flag, a zero clears it
  task automatic fwr(input logic t, c, a);
    flag_wr_in <= 1'h1;
    flag_wr_tick_in <= t;
    flag_wr_countdown_in <= c;
    flag_wr_alarm_in <= a;
    cyc(1);
    flag_wr_in <= 1'h0;
    cyc(2);
  endtask : fwr
  task automatic cd_evt;
    countdown_event_in <= 1'h1;
    cyc(1);
    countdown_event_in <= 1'h0;
  endtask : cd_evt
  task automatic low_len(output int n);
    n = 0;
    cyc(3);
    while (irq_n_out === 1'h0 && n < 9000) begin
      n++;
      cyc(1);
    end
    if (n == 9000) begin
      mismatches++;
      summarize();
    end
  endtask : low_len
  task automatic edges(input int k);
    repeat (k) begin
      tlvl <= 1'h1;
      cyc(8);
      tlvl <= 1'h0;
      cyc(8);
    end
  endtask : edges

  task automatic s_alarm;
    alarm_irq_en_in <= 1'h1;
    alarm_event_in <= 1'h1;
    countdown_event_in <= 1'h1;
    cyc(1);
    alarm_event_in <= 1'h0;
    countdown_event_in <= 1'h0;
    cyc(3);
    chk("irq_alarm", 1'h0, irq_n_out);
    fwr(1'h1, 1'h1, 1'h0);
    chk("alarm_flag", 1'h0, alarm_flag_out);
    chk("cd_flag", 1'h1, countdown_flag_out);
    chk("irq_free", 1'h1, irq_n_out);
    fwr(1'h1, 1'h0, 1'h1);
    alarm_irq_en_in <= 1'h0;
  endtask : s_alarm
  task automatic s_cd;
    logic [1:0] src [4] = '{CD_SRC_4096, CD_SRC_4096, CD_SRC_64, CD_SRC_1_60};
    int w [4] = '{4, 8, 256, 512};
    int n;
    countdown_irq_en_in <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      countdown_src_sel_in <= src[i];
      countdown_reload_one_in <= (i != 1);
      cd_evt();
      low_len(n);
      rng("cd_width", w[i] * 10 - 12, w[i] * 10 + 12, n);
      fwr(1'h1, 1'h0, 1'h1);
    end
    cd_evt();
    cyc(30);
    chk("cd_pulse", 1'h0, irq_n_out);
    fwr(1'h1, 1'h0, 1'h1);
    chk("cd_cut", 1'h1, irq_n_out);
    countdown_irq_en_in <= 1'h0;
    cd_evt();
    cyc(4);
    chk("cd_masked", 1'h1, irq_n_out);
    pulse_mode_sel_in <= 1'h0;
    countdown_irq_en_in <= 1'h1;
    cyc(100);
    chk("cd_level", 1'h0, irq_n_out);
    countdown_irq_en_in <= 1'h0;
    cyc(3);
    chk("cd_level_off", 1'h1, irq_n_out);
    fwr(1'h1, 1'h0, 1'h1);
  endtask : s_cd
  task automatic s_tick;
    slow_tick_irq_en_in <= 1'h1;
    minute_inc_in <= 1'h1;
    cyc(1);
    minute_inc_in <= 1'h0;
    cyc(3);
    chk("minute_flag", 1'h1, tick_flag_out);
    chk("minute_level", 1'h0, irq_n_out);
    fwr(1'h1, 1'h1, 1'h1);
    chk("flag_kept", 1'h1, tick_flag_out);
    slow_tick_irq_en_in <= 1'h0;
    cyc(3);
    chk("tick_off", 1'h1, irq_n_out);
    fwr(1'h0, 1'h1, 1'h1);
  endtask : s_tick
  task automatic s_stop;
    logic [1:0] lo;
    stop_in <= 1'h1;
    cyc(40);
    lo = prescaler_out[1:0];
    chk("stop_hold", 13'h0, prescaler_out[TOP_BIT:STOP_LO]);
    cyc(10);
    chk("low_run", 1'h1, lo !== prescaler_out[1:0]);
    stop_in <= 1'h0;
  endtask : s_stop
  task automatic s_test;
    pulse_mode_sel_in <= 1'h1;
    fast_tick_irq_en_in <= 1'h1;
    external_clock_test_in <= 1'h1;
    tdrv <= 1'h1;
    stop_in <= 1'h1;
    cyc(4);
    stop_in <= 1'h0;
    secs = 0;
    edges(31);
    chk("sec_31", 16'h0, secs);
    edges(1);
    chk("sec_32", 16'h1, secs);
    chk("sec_flag", 1'h1, tick_flag_out);
    chk("sec_pulse", 1'h0, irq_n_out);
    edges(1);
    chk("pulse_end", 1'h1, irq_n_out);
    edges(62);
    chk("sec_95", 16'h1, secs);
    edges(1);
    chk("sec_96", 16'h2, secs);
    fwr(1'h0, 1'h1, 1'h1);
    chk("pulse_cut", 1'h1, irq_n_out);
    stop_in <= 1'h1;
    cyc(3);
    chk("test_stop", 13'h0, prescaler_out[TOP_BIT:STOP_LO]);
    stop_in <= 1'h0;
    external_clock_test_in <= 1'h0;
    tdrv <= 1'h0;
    fast_tick_irq_en_in <= 1'h0;
  endtask : s_test
  task automatic s_sq;
    int t, h, e;
    logic p;
    for (int s = 0; s < 2; s++) begin
      stop_in <= s[0];
      for (int i = 0; i < 8; i++) begin
        square_wave_rate_sel_in <= i[2:0];
        cyc(20);
        t = 0;
        h = 0;
        p = square_wave_pin_in;
        repeat (640) begin
          cyc(1);
          t += int'(square_wave_pin_in !== p);
          h += int'(square_wave_pin_in === 1'h1);
          p = square_wave_pin_in;
        end
        e = (i >= 6 || (s == 1 && i >= 3)) ? 0 : 128 >> i;
        rng("sq_edges", e - 2, e + 2, t);
        if (i == 7 || (s == 1 && i >= 3)) rng("sq_low", 0, 0, h);
        if (i > 0 && e > 0) rng("sq_duty", 316, 324, h);
      end
    end
    square_wave_en_in <= 1'h0;
    cyc(3);
    chk("sq_float", 1'h0, square_wave_pin_oe_out);
    stop_in <= 1'h0;
  endtask : s_sq

  // main sequence
  initial begin
    cyc(3);
    arst_n_in <= 1'h1;
    cyc(2);
    chk("irq_idle", 1'h1, irq_n_out);
    s_alarm();
    s_cd();
    s_tick();
    s_stop();
    s_test();
    s_sq();
    summarize();
  end
endmodule : tb_top
